// ### logic/dma_event_selector.sv
`timescale 1ns/10ps
module dma_event_selector (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // event sources, same clock domain
  input  wire logic        timer0_event,
  input  wire logic        timer1_event,
  input  wire logic        refresh_timer_event,
  input  wire logic        gpio_edge_event_4,
  input  wire logic        gpio_edge_event_5,
  input  wire logic        gpio_edge_event_6,
  input  wire logic        gpio_edge_event_7,
  input  wire logic        gpio_edge_event_2,
  input  wire logic        serial0_tx_event,
  input  wire logic        serial0_rx_event,
  input  wire logic        serial1_tx_event,
  input  wire logic        serial1_rx_event,
  // chaining completions for channels 8-11
  input  wire logic        chain_complete_8,
  input  wire logic        chain_complete_9,
  input  wire logic        chain_complete_10,
  input  wire logic        chain_complete_11,
  // channel synchronization outputs
  output logic      [15:0] channel_sync
);
  import dma_evsel_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [15:0][5:0] codes;       // event code per channel
    logic [15:0]      src_prev;    // previous source levels
    logic [3:0]       chain_prev;  // previous chaining levels
    logic [3:0]       chain_sync;  // registered chaining pulses
    logic [31:0]      rdata;       // read data, one cycle after strobe
  } sel_st_t;

  // reset image: default codes, all else clear
  localparam sel_st_t ST_RESET = '{
    codes:      RESET_CODE,
    src_prev:   '0,
    chain_prev: '0,
    chain_sync: '0,
    rdata:      '0};

  sel_st_t     st_q;         // current state
  sel_st_t     st_d;         // next state
  logic [15:0] src_raw;      // source levels indexed by code
  logic [3:0]  chain_raw;    // chaining levels, channel 8 first
  logic [11:0] prog_sync;    // slice outputs, programmable order
  logic        wr_hit;       // write lands on a selector register
  logic        rd_hit;       // read lands on a selector register
  logic [3:0]  wr_base;      // first channel of written register
  logic [3:0]  rd_base;      // first channel of read register

  event_fabric_if fab ();    // pulses shared by all slices

  ////////////////////////////////////////////////////////////////////////
  // gather sources at their code positions; unused codes stay low
  assign src_raw = {
    serial1_rx_event,     // code 0F
    serial1_tx_event,     // code 0E
    serial0_rx_event,     // code 0D
    serial0_tx_event,     // code 0C
    1'b0,                 // code 0B selects nothing
    gpio_edge_event_2,    // code 0A
    1'b0,                 // code 09 selects nothing
    1'b0,                 // code 08 selects nothing
    gpio_edge_event_7,    // code 07
    gpio_edge_event_6,    // code 06
    gpio_edge_event_5,    // code 05
    gpio_edge_event_4,    // code 04
    refresh_timer_event,  // code 03
    timer1_event,         // code 02
    timer0_event,         // code 01
    1'b0};                // code 00 selects nothing

  assign chain_raw = {chain_complete_11, chain_complete_10, chain_complete_9, chain_complete_8};

  // rising edges only, so a held level gives one pulse
  assign fab.src_pulse = src_raw & ~st_q.src_prev;

  ////////////////////////////////////////////////////////////////////////
  // address decode; the word between second and third is unmapped
  always_comb begin
    wr_hit  = 1'b0;
    rd_hit  = 1'b0;
    wr_base = BASE_0_3;
    rd_base = BASE_0_3;
    case (reg_addr)
      ADDR_ROUTE_0_3: begin
        wr_hit  = reg_wr;
        rd_hit  = reg_rd;
        wr_base = BASE_0_3;
        rd_base = BASE_0_3;
      end
      ADDR_ROUTE_4_7: begin
        wr_hit  = reg_wr;
        rd_hit  = reg_rd;
        wr_base = BASE_4_7;
        rd_base = BASE_4_7;
      end
      ADDR_ROUTE_12_15: begin
        wr_hit  = reg_wr;
        rd_hit  = reg_rd;
        wr_base = BASE_12_15;
        rd_base = BASE_12_15;
      end
      default: begin
        wr_hit  = 1'b0;
        rd_hit  = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state: field writes, read capture, edge history
  always_comb begin
    st_d = st_q;
    // field writes; gap bits are simply never stored
    if (wr_hit) begin
      for (int f = 0; f < FIELDS_PER; f++) begin
        st_d.codes[wr_base + 4'(f)] = reg_wdata[f*FIELD_STRIDE +: CODE_W];
      end
    end
    // read data valid in the next cycle only; unmapped reads zero
    st_d.rdata = '0;
    if (rd_hit) begin
      for (int f = 0; f < FIELDS_PER; f++) begin
        st_d.rdata[f*FIELD_STRIDE +: CODE_W] = st_q.codes[rd_base + 4'(f)];
      end
    end
    // edge history
    st_d.src_prev   = src_raw;
    st_d.chain_prev = chain_raw;
    // chaining channels ignore the selector entirely
    st_d.chain_sync = chain_raw & ~st_q.chain_prev;
  end

  // state register, synchronous reset to default routing
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one slice per programmable channel
  generate
    for (genvar p = 0; p < NUM_PROG; p++) begin : g_prog
      localparam int CH = (p < CHAIN_LO) ? p : p + NUM_CHAIN;
      channel_route_slice u_slice (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .fab        (fab),
        .code_sel   (st_q.codes[CH]),
        .sync_pulse (prog_sync[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign channel_sync = {prog_sync[11:8], st_q.chain_sync, prog_sync[7:0]};
  assign reg_rdata    = st_q.rdata;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  property p_gap_bits_zero;
    reg_rd |=> ((reg_rdata & ~FIELD_MASK) == 32'h00000000);
  endproperty
  a_gap_bits_zero: assert property (p_gap_bits_zero) else $error("gap bits read nonzero");

  property p_gap_word_zero;
    (reg_rd && reg_addr == ADDR_ROUTE_GAP) |=> (reg_rdata == 32'h00000000);
  endproperty
  a_gap_word_zero: assert property (p_gap_word_zero) else $error("unmapped word read nonzero");

  property p_write_read_back;
    (reg_wr && reg_addr == ADDR_ROUTE_4_7) ##1 (reg_rd && reg_addr == ADDR_ROUTE_4_7 && !reg_wr)
      |=> (reg_rdata == ($past(reg_wdata, 2) & FIELD_MASK));
  endproperty
  a_write_read_back: assert property (p_write_read_back) else $error("read back differs from write");

  property p_ch12_field;
    (reg_wr && reg_addr == ADDR_ROUTE_12_15) |=>
      (st_q.codes[12] == $past(reg_wdata[5:0])) && (st_q.codes[15] == $past(reg_wdata[29:24]));
  endproperty
  a_ch12_field: assert property (p_ch12_field) else $error("third register not on channels 12-15");

  property p_reset_defaults;
    $fell(srst) |-> (st_q.codes[7] == CODE_GPIO7) && (st_q.codes[14] == CODE_SER1_TX)
      && (st_q.codes[15] == CODE_SER1_RX) && (st_q.codes[3] == CODE_REFRESH);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("default codes wrong after reset");

  property p_timer0_route;
    ($rose(timer0_event) && st_q.codes[1] == CODE_TIMER0) |=> channel_sync[1] ##1 !channel_sync[1];
  endproperty
  a_timer0_route: assert property (p_timer0_route) else $error("timer0 not routed to channel 1");

  property p_refresh_route;
    ($rose(refresh_timer_event) && st_q.codes[3] == CODE_REFRESH) |=> channel_sync[3];
  endproperty
  a_refresh_route: assert property (p_refresh_route) else $error("refresh event not routed");

  property p_serial1_rx_route;
    ($rose(serial1_rx_event) && st_q.codes[15] == CODE_SER1_RX) |=> channel_sync[15];
  endproperty
  a_serial1_rx_route: assert property (p_serial1_rx_route) else $error("serial1 rx not routed");

  property p_gpio4_route;
    ($rose(gpio_edge_event_4) && st_q.codes[4] == CODE_GPIO4) |=> channel_sync[4];
  endproperty
  a_gpio4_route: assert property (p_gpio4_route) else $error("gpio edge 4 not routed");

  property p_single_pulse;
    ##1 ((channel_sync & $past(channel_sync)) == 16'h0000);
  endproperty
  a_single_pulse: assert property (p_single_pulse) else $error("sync held longer than one cycle");

  property p_chain_pass;
    channel_sync[8] |-> $past(chain_complete_8) && !$past(chain_complete_8, 2);
  endproperty
  a_chain_pass: assert property (p_chain_pass) else $error("channel 8 not driven by chaining");

  property p_rsvd_code;
    (st_q.codes[13] >= CODE_RSVD_LO) |=> !channel_sync[13];
  endproperty
  a_rsvd_code: assert property (p_rsvd_code) else $error("reserved code fired channel 13");

  // main scenarios
  c_fanout: cover property ($rose(timer0_event) ##1 (channel_sync[6] && channel_sync[12]));
  c_gap_read: cover property (reg_rd && reg_addr == ADDR_ROUTE_GAP);
  c_rewrite_route: cover property ((reg_wr && reg_addr == ADDR_ROUTE_12_15) ##[1:20] channel_sync[12]);
  c_chain: cover property (channel_sync[11]);
endmodule

// ### logic/dma_evsel_pkg.sv
package dma_evsel_pkg;
  // selector register byte addresses
  localparam logic [31:0] ADDR_ROUTE_0_3   = 32'h01A0FF00;
  localparam logic [31:0] ADDR_ROUTE_4_7   = 32'h01A0FF04;
  localparam logic [31:0] ADDR_ROUTE_GAP   = 32'h01A0FF08;
  localparam logic [31:0] ADDR_ROUTE_12_15 = 32'h01A0FF0C;
  // field layout
  localparam int          CODE_W       = 6;
  localparam int          FIELD_STRIDE = 8;
  localparam int          FIELDS_PER   = 4;
  localparam logic [31:0] FIELD_MASK   = 32'h3F3F3F3F;
  // channel counts and first channel of each register
  localparam int          NUM_CH       = 16;
  localparam int          NUM_PROG     = 12;
  localparam int          NUM_CHAIN    = 4;
  localparam int          CHAIN_LO     = 8;
  localparam int          EVENT_SPACE  = 16;
  localparam logic [3:0]  BASE_0_3     = 4'h0;
  localparam logic [3:0]  BASE_4_7     = 4'h4;
  localparam logic [3:0]  BASE_12_15   = 4'hC;
  // selector codes
  localparam logic [5:0]  CODE_NONE    = 6'h00;
  localparam logic [5:0]  CODE_TIMER0  = 6'h01;
  localparam logic [5:0]  CODE_TIMER1  = 6'h02;
  localparam logic [5:0]  CODE_REFRESH = 6'h03;
  localparam logic [5:0]  CODE_GPIO4   = 6'h04;
  localparam logic [5:0]  CODE_GPIO5   = 6'h05;
  localparam logic [5:0]  CODE_GPIO6   = 6'h06;
  localparam logic [5:0]  CODE_GPIO7   = 6'h07;
  localparam logic [5:0]  CODE_GPIO2   = 6'h0A;
  localparam logic [5:0]  CODE_SER0_TX = 6'h0C;
  localparam logic [5:0]  CODE_SER0_RX = 6'h0D;
  localparam logic [5:0]  CODE_SER1_TX = 6'h0E;
  localparam logic [5:0]  CODE_SER1_RX = 6'h0F;
  localparam logic [5:0]  CODE_RSVD_LO = 6'h10;
  // per-channel reset codes, chaining channels unused
  localparam logic [15:0][5:0] RESET_CODE = {
    CODE_SER1_RX, CODE_SER1_TX, CODE_SER0_RX, CODE_SER0_TX,
    CODE_NONE, CODE_NONE, CODE_NONE, CODE_NONE,
    CODE_GPIO7, CODE_GPIO6, CODE_GPIO5, CODE_GPIO4,
    CODE_REFRESH, CODE_TIMER1, CODE_TIMER0, CODE_NONE};
endpackage

// ### logic/event_fabric_if.sv
`timescale 1ns/10ps
// one-cycle source pulses indexed by selector code
interface event_fabric_if;
  logic [15:0] src_pulse;  // bit n set: event with code n rose
  modport drive (output src_pulse);
  modport tap   (input  src_pulse);
endinterface

// ### logic/channel_route_slice.sv
`timescale 1ns/10ps
// one programmable channel: picks its source by code, registers the pulse
module channel_route_slice (
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  event_fabric_if.tap                     fab,
  input  wire logic [dma_evsel_pkg::CODE_W-1:0] code_sel,
  output logic                            sync_pulse
);
  import dma_evsel_pkg::*;

  typedef struct packed {
    logic sync;  // registered channel trigger
  } slice_st_t;

  slice_st_t st_q;  // current state
  slice_st_t st_d;  // next state

  ////////////////////////////////////////////////////////////////////////
  // decode: reserved codes connect nothing
  always_comb begin
    st_d = st_q;
    if (code_sel >= CODE_RSVD_LO) begin
      st_d.sync = 1'b0;
    end else begin
      st_d.sync = fab.src_pulse[code_sel[3:0]];
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_pulse = st_q.sync;

  ////////////////////////////////////////////////////////////////////////
  property p_rsvd_silent;
    @(posedge ref_clk) disable iff (srst)
      (code_sel >= CODE_RSVD_LO) |=> !sync_pulse;
  endproperty
  a_rsvd_silent: assert property (p_rsvd_silent) else $error("reserved code triggered channel");

  property p_none_silent;
    @(posedge ref_clk) disable iff (srst)
      (code_sel == CODE_NONE) |=> !sync_pulse;
  endproperty
  a_none_silent: assert property (p_none_silent) else $error("code none triggered channel");
endmodule

// ### verification/dma_channel_model.sv
`timescale 1ns/10ps
// stands in for the controller's sync inputs: counts triggers per channel
module dma_channel_model (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [15:0]      channel_sync,
  output logic      [15:0][7:0] pulse_cnt,
  output logic      [15:0]      wide_seen
);
  logic [15:0] prev_q;  // sync levels one cycle back

  ////////////////////////////////////////////////////////////////////////////
  // count every trigger, flag any trigger that lasts two cycles
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prev_q    <= '0;
      pulse_cnt <= '0;
      wide_seen <= '0;
    end else begin
      prev_q    <= channel_sync;
      wide_seen <= wide_seen | (prev_q & channel_sync);
      for (int i = 0; i < 16; i++) begin
        if (channel_sync[i] === 1'b1) begin
          pulse_cnt[i] <= pulse_cnt[i] + 8'h01;
        end
      end
    end
  end
endmodule

// ### verification/dma_event_selector_bench.sv
`timescale 1ns/10ps
module dma_event_selector_bench;
  import dma_evsel_pkg::*;
  logic             ref_clk, srst, reg_wr, reg_rd;
  logic [31:0]      reg_addr, reg_wdata, reg_rdata;
  logic [15:0]      ev;            // source levels indexed by selector code
  logic [3:0]       chain;         // chaining completions, channels 8-11
  logic [15:0]      channel_sync;
  logic [15:0][7:0] pulse_cnt;
  logic [15:0]      wide_seen;
  logic [5:0]       codes [16];    // shadow of the stored channel codes
  logic [31:0]      rv;
  int               err_count, checked;

  dma_event_selector i_dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer0_event(ev[1]), .timer1_event(ev[2]),
    .refresh_timer_event(ev[3]), .gpio_edge_event_4(ev[4]), .gpio_edge_event_5(ev[5]),
    .gpio_edge_event_6(ev[6]), .gpio_edge_event_7(ev[7]), .gpio_edge_event_2(ev[10]),
    .serial0_tx_event(ev[12]), .serial0_rx_event(ev[13]), .serial1_tx_event(ev[14]),
    .serial1_rx_event(ev[15]), .chain_complete_8(chain[0]), .chain_complete_9(chain[1]),
    .chain_complete_10(chain[2]), .chain_complete_11(chain[3]), .channel_sync(channel_sync));
  dma_channel_model i_model (.ref_clk(ref_clk), .srst(srst), .channel_sync(channel_sync),
    .pulse_cnt(pulse_cnt), .wide_seen(wide_seen));

  ////////////////////////////////////////////////////////////////////////////
  // comparisons and closing
  task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // register port master; writes also update the shadow codes
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int b;
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    b = (a == ADDR_ROUTE_0_3) ? 0 : (a == ADDR_ROUTE_4_7) ? 4 : (a == ADDR_ROUTE_12_15) ? 12 : -1;
    if (b >= 0) for (int f = 0; f < 4; f++) codes[b+f] = d[8*f +: 6];
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // write the second register, then read it back in the very next cycle
  task automatic wr_rd(input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= ADDR_ROUTE_4_7; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0; reg_rd <= 1'b1;
    for (int f = 0; f < 4; f++) codes[4+f] = d[8*f +: 6];
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // one event pulse set, expected triggers worked out from the shadow codes
  task automatic fire(input logic [15:0] e, input logic [3:0] c);
    logic [15:0] exp;
    exp = '0;
    for (int ch = 0; ch < 16; ch++) begin
      if (ch >= 8 && ch <= 11) exp[ch] = c[ch-8];
      else exp[ch] = (codes[ch] < 6'h10) && e[codes[ch][3:0]];
    end
    @(posedge ref_clk);
    ev <= e; chain <= c;
    @(posedge ref_clk);
    ev <= '0; chain <= '0;
    #1 chk16("channel_sync", exp, channel_sync);
    @(posedge ref_clk);
    #1 chk16("channel_sync_after", 16'h0000, channel_sync);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_values;
    rd(ADDR_ROUTE_0_3, rv);   chk32("route_0_3", 32'h03020100, rv);
    rd(ADDR_ROUTE_4_7, rv);   chk32("route_4_7", 32'h07060504, rv);
    rd(ADDR_ROUTE_12_15, rv); chk32("route_12_15", 32'h0F0E0D0C, rv);
    rd(ADDR_ROUTE_GAP, rv);   chk32("route_gap", 32'h00000000, rv);
  endtask
  task automatic t_reg_access;
    wr(ADDR_ROUTE_0_3, 32'hFFFFFFFF);
    wr(ADDR_ROUTE_4_7, 32'hC0FFEE2A);
    wr(ADDR_ROUTE_12_15, 32'h15263748);
    wr(ADDR_ROUTE_GAP, 32'hFFFFFFFF);
    rd(ADDR_ROUTE_0_3, rv);   chk32("route_0_3", 32'h3F3F3F3F, rv);
    rd(ADDR_ROUTE_4_7, rv);   chk32("route_4_7", 32'h003F2E2A, rv);
    rd(ADDR_ROUTE_12_15, rv); chk32("route_12_15", 32'h15263708, rv);
    rd(ADDR_ROUTE_GAP, rv);   chk32("route_gap", 32'h00000000, rv);
    wr_rd(32'hFF4D6C81, rv);  chk32("route_4_7_b2b", 32'h3F0D2C01, rv);
  endtask
  // each source alone against the current routing; gpio sources act as enabled inputs
  task automatic t_each_event;
    for (int e = 0; e < 16; e++) fire(16'h0001 << e & 16'hF4FE, 4'h0);
  endtask
  task automatic t_fanout_reserved;
    wr(ADDR_ROUTE_0_3, 32'h0B09080A);
    wr(ADDR_ROUTE_4_7, 32'h01013F10);
    wr(ADDR_ROUTE_12_15, 32'h203F0A01);
    t_each_event();
    fire(16'hF4FE, 4'hF);
    fire(16'h0000, 4'h5);
  endtask
  // a source held high triggers its channel once
  task automatic t_held_source;
    logic [7:0] base;
    base = pulse_cnt[6];
    @(posedge ref_clk);
    ev <= 16'h0002;
    repeat (4) @(posedge ref_clk);
    ev <= '0;
    repeat (2) @(posedge ref_clk);
    #1 chk32("held_count", 32'h00000001, {24'h0, pulse_cnt[6] - base});
  endtask
  task automatic t_rereset;
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++) codes[i] = (i >= 8 && i <= 11) ? 6'h00 : 6'(i);
    t_reset_values();
    t_each_event();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock, watchdog, main sequence
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    err_count++;
    final_report();
  end
  initial begin
    srst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
    ev = '0; chain = '0; err_count = 0; checked = 0;
    for (int i = 0; i < 16; i++) codes[i] = (i >= 8 && i <= 11) ? 6'h00 : 6'(i);
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset_values();
    t_each_event();
    t_reg_access();
    t_fanout_reserved();
    t_held_source();
    chk16("wide_pulses_pre", 16'h0000, wide_seen);
    t_rereset();
    chk16("wide_pulses", 16'h0000, wide_seen);
    final_report();
  end
endmodule
